// ### verilog/cpureg_pkg.sv
// package: constants, commands and carriers for the cpu core register file
package cpureg_pkg;

	// ------------------------------------------------------------
	// register map (word offsets on the wishbone bus)
	// ------------------------------------------------------------
	localparam logic [7:0] CPUREG_OFF_ACC    = 8'h00;
	localparam logic [7:0] CPUREG_OFF_IDX1   = 8'h04;
	localparam logic [7:0] CPUREG_OFF_IDX2   = 8'h08;
	localparam logic [7:0] CPUREG_OFF_STACK  = 8'h0C;
	localparam logic [7:0] CPUREG_OFF_PSW    = 8'h10;
	localparam logic [7:0] CPUREG_OFF_PAIR   = 8'h14;
	localparam logic [7:0] CPUREG_OFF_CMD    = 8'h18;
	localparam logic [7:0] CPUREG_OFF_RESULT = 8'h1C;
	localparam logic [7:0] CPUREG_OFF_STKADR = 8'h20;

	// ------------------------------------------------------------
	// status word bit positions
	// ------------------------------------------------------------
	localparam int CPUREG_BIT_C = 0;
	localparam int CPUREG_BIT_Z = 1;
	localparam int CPUREG_BIT_I = 2;
	localparam int CPUREG_BIT_H = 3;
	localparam int CPUREG_BIT_B = 4;
	localparam int CPUREG_BIT_G = 5;
	localparam int CPUREG_BIT_V = 6;
	localparam int CPUREG_BIT_N = 7;

	// ------------------------------------------------------------
	// values
	// ------------------------------------------------------------
	localparam logic [7:0]  CPUREG_RST_ZERO    = 8'h00;
	localparam logic [7:0]  CPUREG_STACK_TOP   = 8'hBF;
	localparam logic [7:0]  CPUREG_MASK_HV     = 8'h48;
	localparam logic [31:0] CPUREG_UNMAPPED    = 32'h0000_0000;

	// command codes written to the command register, bits [3:0]
	typedef enum logic [3:0] {
		CPUREG_OP_NOP,
		CPUREG_OP_ADD,
		CPUREG_OP_SUB,
		CPUREG_OP_SHL,
		CPUREG_OP_ROR,
		CPUREG_OP_INCX,
		CPUREG_OP_DECX,
		CPUREG_OP_CMPX,
		CPUREG_OP_INCY,
		CPUREG_OP_DECY,
		CPUREG_OP_MOV,
		CPUREG_OP_BITTEST,
		CPUREG_OP_PUSH,
		CPUREG_OP_POP,
		CPUREG_OP_FLAG,
		CPUREG_OP_IRQ
	} cpureg_op_t;

	// flag sub-commands in command bits [7:4] with CPUREG_OP_FLAG
	localparam logic [3:0] CPUREG_F_EI   = 4'h1;
	localparam logic [3:0] CPUREG_F_DI   = 4'h2;
	localparam logic [3:0] CPUREG_F_CLEAR_OVERFLOW_INSTR = 4'h3;
	localparam logic [3:0] CPUREG_F_SET_PAGE_INSTR = 4'h4;
	localparam logic [3:0] CPUREG_F_CLEAR_PAGE_INSTR = 4'h5;
	localparam logic [3:0] CPUREG_F_BRK  = 4'h6;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  acc;
		logic [7:0]  idx1;
		logic [7:0]  idx2;
		logic [7:0]  stack;
		logic [7:0]  program_status_word;
		logic [7:0]  result;
		logic [7:0]  stkadr;
		logic [31:0] rdata;
		logic        ack;
		logic        irq_ok;
	} cpureg_state_t;

endpackage

// ### verilog/cpureg_core.sv
// cpu core registers, stack pointer and status flags behind a wishbone slave
`timescale 1ns/1ps

module cpureg_core
	import cpureg_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// decoder side: operand, base address, index select, direct mode
	input  wire logic [7:0]  mem_data_i,
	input  wire logic [7:0]  base_addr_i,
	input  wire logic        addr_use_y_i,
	input  wire logic        direct_mode_i,
	// addressing and status outputs
	output logic      [8:0]  eff_addr_o,
	output logic      [7:0]  stack_addr_o,
	output logic      [7:0]  psw_o,
	output logic             irq_accept_o
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	cpureg_state_t st_reg;
	cpureg_state_t st_next;
	logic [8:0]    eff_reg;
	logic [8:0]    eff_next;

	logic          req;
	logic          wr;
	logic [7:0]    wb0;
	logic [7:0]    wb1;
	cpureg_op_t    op;
	logic [3:0]    sub;
	logic [8:0]    sum;
	logic [4:0]    low;
	logic [7:0]    res;
	logic [7:0]    b;
	logic          do_alu;

	assign req = cyc_i & stb_i & ~st_reg.ack;
	assign wr  = req & we_i;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_next        = st_reg;
		eff_next       = eff_reg;
		st_next.ack    = req;
		st_next.irq_ok = 1'b0;
		sum            = 9'h000;
		low            = 5'h00;
		res            = 8'h00;
		do_alu         = 1'b0;
		wb0            = sel_i[0] ? dat_i[7:0] : 8'h00;
		wb1            = sel_i[1] ? dat_i[15:8] : 8'h00;
		op             = cpureg_op_t'(dat_i[3:0]);
		sub            = dat_i[7:4];
		b              = mem_data_i;

		// effective address: page flag and base in direct mode, else base plus index on page 0
		if (direct_mode_i) begin
			eff_next = {st_reg.program_status_word[CPUREG_BIT_G], base_addr_i};
		end else begin
			eff_next = {1'b0, base_addr_i + (addr_use_y_i ? st_reg.idx2 : st_reg.idx1)};
		end

		// register reads
		if (req && !we_i) begin
			unique case (adr_i)
				CPUREG_OFF_ACC:    st_next.rdata = {24'h000000, st_reg.acc};
				CPUREG_OFF_IDX1:   st_next.rdata = {24'h000000, st_reg.idx1};
				CPUREG_OFF_IDX2:   st_next.rdata = {24'h000000, st_reg.idx2};
				CPUREG_OFF_STACK:  st_next.rdata = {24'h000000, st_reg.stack};
				CPUREG_OFF_PSW:    st_next.rdata = {24'h000000, st_reg.program_status_word};
				CPUREG_OFF_PAIR:   st_next.rdata = {16'h0000, st_reg.idx2, st_reg.acc};
				CPUREG_OFF_RESULT: st_next.rdata = {24'h000000, st_reg.result};
				CPUREG_OFF_STKADR: st_next.rdata = {24'h000000, st_reg.stkadr};
				default:           st_next.rdata = CPUREG_UNMAPPED;
			endcase
		end

		// register writes and commands
		if (wr) begin
			unique case (adr_i)
				CPUREG_OFF_ACC: if (sel_i[0]) st_next.acc = wb0;
				CPUREG_OFF_IDX1: if (sel_i[0]) st_next.idx1 = wb0;
				CPUREG_OFF_IDX2: if (sel_i[0]) st_next.idx2 = wb0;
				CPUREG_OFF_STACK: if (sel_i[0]) st_next.stack = wb0;
				CPUREG_OFF_PSW: if (sel_i[0]) st_next.program_status_word = wb0;
				CPUREG_OFF_PAIR: begin
					if (sel_i[0]) st_next.acc = wb0;
					if (sel_i[1]) st_next.idx2 = wb1;
				end
				CPUREG_OFF_CMD: if (sel_i[0]) begin
					unique case (op)
						CPUREG_OP_ADD: begin
							sum = {1'b0, st_reg.acc} + {1'b0, b};
							low = {1'b0, st_reg.acc[3:0]} + {1'b0, b[3:0]};
							res = sum[7:0];
							st_next.acc = res;
							st_next.program_status_word[CPUREG_BIT_C] = sum[8];
							st_next.program_status_word[CPUREG_BIT_H] = low[4];
							st_next.program_status_word[CPUREG_BIT_V] =
								(st_reg.acc[7] == b[7]) && (res[7] != b[7]);
							do_alu = 1'b1;
						end
						CPUREG_OP_SUB: begin
							sum = {1'b0, st_reg.acc} - {1'b0, b};
							low = {1'b0, st_reg.acc[3:0]} - {1'b0, b[3:0]};
							res = sum[7:0];
							st_next.acc = res;
							st_next.program_status_word[CPUREG_BIT_C] = ~sum[8];
							st_next.program_status_word[CPUREG_BIT_H] = ~low[4];
							st_next.program_status_word[CPUREG_BIT_V] =
								(st_reg.acc[7] != b[7]) && (res[7] != st_reg.acc[7]);
							do_alu = 1'b1;
						end
						CPUREG_OP_SHL: begin
							res = {st_reg.acc[6:0], 1'b0};
							st_next.acc = res;
							st_next.program_status_word[CPUREG_BIT_C] = st_reg.acc[7];
							do_alu = 1'b1;
						end
						CPUREG_OP_ROR: begin
							res = {st_reg.program_status_word[CPUREG_BIT_C], st_reg.acc[7:1]};
							st_next.acc = res;
							st_next.program_status_word[CPUREG_BIT_C] = st_reg.acc[0];
							do_alu = 1'b1;
						end
						CPUREG_OP_INCX: begin
							res = st_reg.idx1 + 8'h01;
							st_next.idx1 = res;
							do_alu = 1'b1;
						end
						CPUREG_OP_DECX: begin
							res = st_reg.idx1 - 8'h01;
							st_next.idx1 = res;
							do_alu = 1'b1;
						end
						CPUREG_OP_CMPX: begin
							sum = {1'b0, st_reg.idx1} - {1'b0, b};
							res = sum[7:0];
							st_next.program_status_word[CPUREG_BIT_C] = ~sum[8];
							do_alu = 1'b1;
						end
						CPUREG_OP_INCY: begin
							res = st_reg.idx2 + 8'h01;
							st_next.idx2 = res;
							do_alu = 1'b1;
						end
						CPUREG_OP_DECY: begin
							res = st_reg.idx2 - 8'h01;
							st_next.idx2 = res;
							do_alu = 1'b1;
						end
						CPUREG_OP_MOV: begin
							res = b;
							st_next.acc = res;
							do_alu = 1'b1;
						end
						CPUREG_OP_BITTEST: begin
							st_next.program_status_word[CPUREG_BIT_V] = b[6];
							st_next.program_status_word[CPUREG_BIT_N] = b[7];
							st_next.program_status_word[CPUREG_BIT_Z] = ((st_reg.acc & b) == 8'h00);
						end
						CPUREG_OP_PUSH: begin
							// save at current pointer, then move down
							st_next.stkadr = st_reg.stack;
							st_next.stack  = st_reg.stack - 8'h01;
						end
						CPUREG_OP_POP: begin
							// move up first, then restore from there
							st_next.stack  = st_reg.stack + 8'h01;
							st_next.stkadr = st_reg.stack + 8'h01;
						end
						CPUREG_OP_IRQ: begin
							if (st_reg.program_status_word[CPUREG_BIT_I]) begin
								st_next.program_status_word[CPUREG_BIT_I] = 1'b0;
								st_next.stkadr = st_reg.stack;
								st_next.stack  = st_reg.stack - 8'h01;
								st_next.irq_ok = 1'b1;
							end
						end
						CPUREG_OP_FLAG: begin
							if (sub == CPUREG_F_EI) st_next.program_status_word[CPUREG_BIT_I] = 1'b1;
							if (sub == CPUREG_F_DI) st_next.program_status_word[CPUREG_BIT_I] = 1'b0;
							if (sub == CPUREG_F_CLEAR_OVERFLOW_INSTR) begin
								st_next.program_status_word = st_reg.program_status_word & ~CPUREG_MASK_HV;
							end
							if (sub == CPUREG_F_SET_PAGE_INSTR) st_next.program_status_word[CPUREG_BIT_G] = 1'b1;
							if (sub == CPUREG_F_CLEAR_PAGE_INSTR) st_next.program_status_word[CPUREG_BIT_G] = 1'b0;
							if (sub == CPUREG_F_BRK) begin
								// break is taken regardless of the enable flag
								st_next.program_status_word[CPUREG_BIT_B] = 1'b1;
								st_next.stkadr = st_reg.stack;
								st_next.stack  = st_reg.stack - 8'h01;
							end
						end
						CPUREG_OP_NOP: ;
					endcase
				end
				default: ;
			endcase
		end

		if (do_alu) begin
			st_next.result = res;
			st_next.program_status_word[CPUREG_BIT_Z] = (res == 8'h00);
			st_next.program_status_word[CPUREG_BIT_N] = res[7];
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// data registers and the stack pointer keep no reset value on purpose
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg.ack    <= 1'b0;
			st_reg.irq_ok <= 1'b0;
			st_reg.rdata  <= CPUREG_UNMAPPED;
			st_reg.program_status_word    <= CPUREG_RST_ZERO;
			st_reg.result <= CPUREG_RST_ZERO;
			st_reg.stkadr <= CPUREG_RST_ZERO;
			st_reg.acc    <= st_next.acc;
			st_reg.idx1   <= st_next.idx1;
			st_reg.idx2   <= st_next.idx2;
			st_reg.stack  <= st_next.stack;
			eff_reg       <= 9'h000;
		end else begin
			st_reg  <= st_next;
			eff_reg <= eff_next;
		end
	end

	assign dat_o        = st_reg.rdata;
	assign ack_o        = st_reg.ack;
	assign psw_o        = st_reg.program_status_word;
	assign stack_addr_o = st_reg.stkadr;
	assign irq_accept_o = st_reg.irq_ok;
	assign eff_addr_o   = eff_reg;

endmodule // cpureg_core

// ### sim/cpureg_core_props.sv
// port assertions for the cpu core register file
`timescale 1ns/1ps
module cpureg_core_props
	import cpureg_pkg::*;
(
	// all ports of the core
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic [7:0]  mem_data_i,
	input wire logic [7:0]  base_addr_i,
	input wire logic        addr_use_y_i,
	input wire logic        direct_mode_i,
	input wire logic [8:0]  eff_addr_o,
	input wire logic [7:0]  stack_addr_o,
	input wire logic [7:0]  psw_o,
	input wire logic        irq_accept_o
);
	default clocking dc @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack_one;
		ack_o |=> !ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack held too long");
	property p_ack_req;
		cyc_i && stb_i && !ack_o |=> ack_o;
	endproperty
	a_ack_req: assert property (p_ack_req) else $error("request not answered");
	property p_ack_cause;
		ack_o |-> $past(cyc_i && stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_unmapped;
		cyc_i && stb_i && !we_i && !ack_o && adr_i == 8'h30 |=> dat_o == CPUREG_UNMAPPED;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	// page flag sampled while no command can move it
	property p_eff_direct;
		direct_mode_i && !(cyc_i && stb_i)
			|=> eff_addr_o == {$past(psw_o[CPUREG_BIT_G]), $past(base_addr_i)};
	endproperty
	a_eff_direct: assert property (p_eff_direct) else $error("direct address wrong");
	property p_irq_gate;
		irq_accept_o |-> $past(psw_o[CPUREG_BIT_I]) && !psw_o[CPUREG_BIT_I];
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt gate wrong");
	property p_irq_cause;
		irq_accept_o |-> $past(cyc_i && stb_i && we_i && adr_i == CPUREG_OFF_CMD);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("accept without command");
	property p_g_cmd;
		$changed(psw_o[CPUREG_BIT_G]) |-> $past(cyc_i && stb_i && we_i);
	endproperty
	a_g_cmd: assert property (p_g_cmd) else $error("page flag moved alone");
	property p_v_set;
		$rose(psw_o[CPUREG_BIT_V]) |-> $past(cyc_i && stb_i && we_i);
	endproperty
	a_v_set: assert property (p_v_set) else $error("overflow set alone");
endmodule // cpureg_core_props

bind cpureg_core cpureg_core_props props (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .mem_data_i(mem_data_i),
	.base_addr_i(base_addr_i), .addr_use_y_i(addr_use_y_i), .direct_mode_i(direct_mode_i),
	.eff_addr_o(eff_addr_o), .stack_addr_o(stack_addr_o), .psw_o(psw_o),
	.irq_accept_o(irq_accept_o)
);

// ### sim/cpureg_core_bench.sv
// self-checking bench for the cpu core register file
`timescale 1ns/1ps
module cpureg_core_bench
	import cpureg_pkg::*;
;
	logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic        use_y = 1'b0, dmode = 1'b0, ack, irqa, irq_seen;
	logic [7:0]  adr = 8'h00, mem = 8'h00, base = 8'h00, sadr, program_status_word;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic [8:0]  eff;
	int          n_errors = 0, check_count = 0, cycles = 0;
	wire  [31:0] pw = {24'h0, program_status_word};
	wire  [31:0] ew = {23'h0, eff};
	wire  [31:0] sw = {24'h0, sadr};

	always #4 clk = ~clk;

	cpureg_core uut (
		.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .mem_data_i(mem),
		.base_addr_i(base), .addr_use_y_i(use_y), .direct_mode_i(dmode),
		.eff_addr_o(eff), .stack_addr_o(sadr), .psw_o(program_status_word), .irq_accept_o(irqa)
	);

	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// a hung handshake ends here
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			n_errors = n_errors + 1;
			report_and_stop();
		end
	end

	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", name, e, g);
		end
	endtask

	// one wishbone classic cycle; read data and accept pulse taken at the ack edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [7:0] m);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		mem <= m;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = rdat;
		irq_seen = irqa;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, mem);
	endtask

	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0, mem);
	endtask

	task automatic cmd(input cpureg_op_t op, input logic [3:0] sub, input logic [7:0] m);
		bus(1'b1, CPUREG_OFF_CMD, {24'h0, sub, op}, m);
	endtask

	task automatic setaddr(input logic [7:0] b, input logic y, input logic dm);
		@(posedge clk);
		base <= b;
		use_y <= y;
		dmode <= dm;
		repeat (2) @(posedge clk);
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		chk("psw", 32'h0, pw);
		wr(CPUREG_OFF_ACC, 32'h5A);
		wr(CPUREG_OFF_IDX1, 32'h10);
		wr(CPUREG_OFF_IDX2, 32'h20);
		wr(CPUREG_OFF_STACK, {24'h0, CPUREG_STACK_TOP});
		rd(CPUREG_OFF_ACC);
		chk("acc", 32'h5A, q);
		rd(CPUREG_OFF_PAIR);
		chk("pair", 32'h205A, q);
		rd(8'h30);
		chk("unmapped", CPUREG_UNMAPPED, q);
		wr(CPUREG_OFF_PAIR, 32'h3344);
		rd(CPUREG_OFF_IDX2);
		chk("idx2", 32'h33, q);
		setaddr(8'h08, 1'b0, 1'b0);
		chk("eff x", 32'h18, ew);
		setaddr(8'h40, 1'b1, 1'b0);
		chk("eff y", 32'h73, ew);
		cmd(CPUREG_OP_INCX, 4'h0, 8'h00);
		rd(CPUREG_OFF_IDX1);
		chk("idx1", 32'h11, q);
		cmd(CPUREG_OP_DECY, 4'h0, 8'h00);
		rd(CPUREG_OFF_IDX2);
		chk("idx2", 32'h32, q);
		cmd(CPUREG_OP_PUSH, 4'h0, 8'h00);
		chk("push addr", 32'hBF, sw);
		rd(CPUREG_OFF_STACK);
		chk("sp push", 32'hBE, q);
		cmd(CPUREG_OP_POP, 4'h0, 8'h00);
		chk("pop addr", 32'hBF, sw);
		cmd(CPUREG_OP_IRQ, 4'h0, 8'h00);
		chk("irq masked", 32'h0, {31'h0, irq_seen});
		cmd(CPUREG_OP_FLAG, CPUREG_F_EI, 8'h00);
		chk("ei", 32'h4, pw & 32'h4);
		cmd(CPUREG_OP_IRQ, 4'h0, 8'h00);
		chk("irq taken", 32'h1, {31'h0, irq_seen});
		chk("irq clears i", 32'h0, pw & 32'h4);
		cmd(CPUREG_OP_FLAG, CPUREG_F_EI, 8'h00);
		cmd(CPUREG_OP_FLAG, CPUREG_F_DI, 8'h00);
		chk("di", 32'h0, pw & 32'h4);
		cmd(CPUREG_OP_FLAG, CPUREG_F_SET_PAGE_INSTR, 8'h00);
		setaddr(8'h42, 1'b0, 1'b1);
		chk("page 1", 32'h142, ew);
		cmd(CPUREG_OP_FLAG, CPUREG_F_CLEAR_PAGE_INSTR, 8'h00);
		setaddr(8'h42, 1'b0, 1'b1);
		chk("page 0", 32'h042, ew);
		wr(CPUREG_OFF_ACC, 32'h7F);
		cmd(CPUREG_OP_ADD, 4'h0, 8'h01);
		chk("add ovf", 32'hC8, pw & 32'hCB);
		cmd(CPUREG_OP_FLAG, CPUREG_F_CLEAR_OVERFLOW_INSTR, 8'h00);
		chk("clear_overflow_instr", 32'h0, pw & 32'h48);
		wr(CPUREG_OFF_ACC, 32'hFF);
		cmd(CPUREG_OP_ADD, 4'h0, 8'h01);
		chk("add zero", 32'h0B, pw & 32'hCB);
		wr(CPUREG_OFF_ACC, 32'h81);
		cmd(CPUREG_OP_SHL, 4'h0, 8'h00);
		chk("shift carry", 32'h1, pw & 32'h1);
		cmd(CPUREG_OP_BITTEST, 4'h0, 8'hC0);
		chk("bit test", 32'hC0, pw & 32'hC0);
		cmd(CPUREG_OP_FLAG, CPUREG_F_BRK, 8'h00);
		chk("break", 32'h10, pw & 32'h10);
		chk("break push", 32'hBE, sw);
		rd(CPUREG_OFF_STKADR);
		chk("stkadr", 32'hBE, q);
		wr(CPUREG_OFF_ACC, 32'h50);
		cmd(CPUREG_OP_SUB, 4'h0, 8'hB0);
		chk("sub ovf", 32'hC8, pw & 32'hCB);
		wr(CPUREG_OFF_ACC, 32'h01);
		cmd(CPUREG_OP_ROR, 4'h0, 8'h00);
		chk("ror carry", 32'h3, pw & 32'h3);
		cmd(CPUREG_OP_ROR, 4'h0, 8'h00);
		rd(CPUREG_OFF_RESULT);
		chk("ror result", 32'h80, q);
		cmd(CPUREG_OP_CMPX, 4'h0, 8'h12);
		chk("cmpx less", 32'h80, pw & 32'h83);
		cmd(CPUREG_OP_CMPX, 4'h0, 8'h11);
		chk("cmpx equal", 32'h3, pw & 32'h83);
		cmd(CPUREG_OP_MOV, 4'h0, 8'h00);
		chk("mov zero", 32'h2, pw & 32'h82);
		rd(CPUREG_OFF_ACC);
		chk("mov acc", 32'h0, q);
		cmd(CPUREG_OP_DECX, 4'h0, 8'h00);
		rd(CPUREG_OFF_IDX1);
		chk("decx", 32'h10, q);
		cmd(CPUREG_OP_INCY, 4'h0, 8'h00);
		rd(CPUREG_OFF_IDX2);
		chk("incy", 32'h33, q);
		report_and_stop();
	end
endmodule // cpureg_core_bench
